/* File: hdl/serial_adc_frame_timing.sv */
// Device side of the serial converter frame: sampling and readout.
`timescale 1ns/1ns
// Operation
// - Frame lasts 14 or 16 sclk periods.
// - Drive data line soon after select falls.
// - New bit after each sclk falling edge.
// - Release data line after final falling edge.
// - Four zeros, then result MSB first.
// - Frame select starts conversion and frames transfer.
// - Serial clock alone paces the conversion.
module serial_adc_frame_timing
	import adc_frame_pkg::*;
#(
	parameter int RESULT_BITS = RESULT_BITS_12
) (
	input  wire logic                   clk_sys_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   frame_sel_n_i,
	input  wire logic                   sclk_i,
	input  wire logic [RESULT_BITS-1:0] sample_value_i,
	output logic                        serial_result_out_o,
	output logic                        serial_result_oe_o,
	output logic                        busy_o,
	output logic [RESULT_BITS-1:0]      held_sample_o
);
	localparam int FRAME_LEN =
		(RESULT_BITS == RESULT_BITS_10) ? FRAME_LEN_10 : FRAME_LEN_12;
	localparam logic [CNT_W-1:0] FRAME_LEN_C = CNT_W'(FRAME_LEN);
	localparam int TRAIL = SHIFT_BITS - LEAD_ZEROS - RESULT_BITS;

	adc_pin_if pins ();

	adc_pin_sync u_sync (
		.clk_sys_i     (clk_sys_i),
		.sys_rst_i     (sys_rst_i),
		.frame_sel_n_i (frame_sel_n_i),
		.sclk_i        (sclk_i),
		.pins          (pins.sync)
	);

	frame_state_t            state_reg;
	frame_state_t            state_next;
	logic [CNT_W-1:0]        fall_cnt_reg;
	logic [CNT_W-1:0]        fall_cnt_next;
	logic [SHIFT_BITS-1:0]   shift_reg;
	logic [SHIFT_BITS-1:0]   shift_next;
	logic                    out_reg;
	logic                    out_next;
	logic                    oe_reg;
	logic                    oe_next;
	logic [RESULT_BITS-1:0]  hold_reg;
	logic [RESULT_BITS-1:0]  hold_next;
	wire  [SHIFT_BITS-1:0]   frame_word;
	wire                     last_fall;

	// Word laid out as leading zeros, result, then trailing zeros only when TRAIL > 0.
	generate
		if (TRAIL > 0) begin : g_trail
			assign frame_word = {{LEAD_ZEROS{1'b0}}, sample_value_i,
				{TRAIL{1'b0}}};
		end else begin : g_notrail
			assign frame_word = {{LEAD_ZEROS{1'b0}},
				sample_value_i};
		end
	endgenerate

	assign last_fall = pins.sclk_fall
		&& (fall_cnt_reg == FRAME_LEN_C - CNT_ONE);

	always_comb begin
		state_next    = state_reg;
		fall_cnt_next = fall_cnt_reg;
		shift_next    = shift_reg;
		out_next      = out_reg;
		oe_next       = oe_reg;
		hold_next     = hold_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (pins.frame_start) begin
					hold_next     = sample_value_i;
					shift_next    = {frame_word[SHIFT_BITS-2:0], 1'b0};
					out_next      = frame_word[SHIFT_BITS-1];
					oe_next       = 1'b1;
					fall_cnt_next = CNT_ZERO;
					state_next    = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (pins.frame_end) begin
					oe_next    = 1'b0;
					out_next   = 1'b0;
					state_next = ST_IDLE;
				end else if (last_fall) begin
					oe_next    = 1'b0;
					out_next   = 1'b0;
					state_next = ST_DONE;
				end else if (pins.sclk_fall) begin
					out_next      = shift_reg[SHIFT_BITS-1];
					shift_next    = {shift_reg[SHIFT_BITS-2:0], 1'b0};
					fall_cnt_next = fall_cnt_reg + CNT_ONE;
				end
			end
			ST_DONE: begin
				if (pins.frame_end) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg    <= ST_IDLE;
			fall_cnt_reg <= CNT_ZERO;
			shift_reg    <= SHIFT_ZERO;
			out_reg      <= 1'b0;
			oe_reg       <= 1'b0;
			hold_reg     <= '0;
		end else begin
			state_reg    <= state_next;
			fall_cnt_reg <= fall_cnt_next;
			shift_reg    <= shift_next;
			out_reg      <= out_next;
			oe_reg       <= oe_next;
			hold_reg     <= hold_next;
		end
	end

	assign serial_result_out_o = out_reg;
	assign serial_result_oe_o  = oe_reg;
	assign busy_o              = (state_reg == ST_SHIFT);
	assign held_sample_o       = hold_reg;
endmodule

/* File: hdl/adc_frame_pkg.sv */
// Constants and types for the serial converter frame timing block.
package adc_frame_pkg;
	localparam int CLK_SYS_HZ        = 50_000_000;
	localparam int FRAME_LEN_12      = 16;
	localparam int FRAME_LEN_10      = 14;
	localparam int LEAD_ZEROS        = 4;
	localparam int RESULT_BITS_12    = 12;
	localparam int RESULT_BITS_10    = 10;
	localparam int SHIFT_BITS        = 16;
	localparam int CNT_W             = 5;
	localparam int QUIET_NS          = 50;
	localparam int ACQ_NS            = 250;
	localparam int WAKE_DELAY_NS     = 1000;
	localparam int SCLK_MIN_HZ       = 10_000;
	localparam int SCLK_MAX_HZ       = 5_000_000;
	localparam int QUIET_CYC =
		(QUIET_NS * (CLK_SYS_HZ / 1_000_000) + 999) / 1000;
	localparam int ACQ_CYC =
		(ACQ_NS * (CLK_SYS_HZ / 1_000_000) + 999) / 1000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
	localparam logic [SHIFT_BITS-1:0] SHIFT_ZERO = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_DONE
	} frame_state_t;
endpackage

/* File: hdl/adc_pin_if.sv */
// Interface carrying the synchronised pin levels and their edge events.
`timescale 1ns/1ns
interface adc_pin_if;
	logic frame_sel_n;
	logic sclk;
	logic frame_start;
	logic frame_end;
	logic sclk_fall;
	modport sync (
		output frame_sel_n,
		output sclk,
		output frame_start,
		output frame_end,
		output sclk_fall
	);
	modport core (
		input frame_sel_n,
		input sclk,
		input frame_start,
		input frame_end,
		input sclk_fall
	);
endinterface

/* File: hdl/adc_pin_sync.sv */
// Two-stage synchronisers and edge detection for frame select and sclk.
`timescale 1ns/1ns
module adc_pin_sync (
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	input  wire logic frame_sel_n_i,
	input  wire logic sclk_i,
	adc_pin_if.sync   pins
);
	logic [1:0] cs_meta_reg;
	logic [1:0] ck_meta_reg;
	logic       cs_last_reg;
	logic       ck_last_reg;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cs_meta_reg <= 2'h3;
			ck_meta_reg <= 2'h0;
			cs_last_reg <= 1'b1;
			ck_last_reg <= 1'b0;
		end else begin
			cs_meta_reg <= {cs_meta_reg[0], frame_sel_n_i};
			ck_meta_reg <= {ck_meta_reg[0], sclk_i};
			cs_last_reg <= cs_meta_reg[1];
			ck_last_reg <= ck_meta_reg[1];
		end
	end

	assign pins.frame_sel_n = cs_meta_reg[1];
	assign pins.sclk        = ck_meta_reg[1];
	assign pins.frame_start = cs_last_reg & ~cs_meta_reg[1];
	assign pins.frame_end   = ~cs_last_reg & cs_meta_reg[1];
	assign pins.sclk_fall   = ck_last_reg & ~ck_meta_reg[1];
endmodule

/* File: testbench/adc_frame_sva.sv */
// Checker for the converter frame pins.
`timescale 1ns/1ns
module adc_frame_sva
	import adc_frame_pkg::*;
#(
	parameter int RESULT_BITS = RESULT_BITS_12
) (
	input wire logic                   clk_sys_i,
	input wire logic                   sys_rst_i,
	input wire logic                   frame_sel_n_i,
	input wire logic                   sclk_i,
	input wire logic [RESULT_BITS-1:0] sample_value_i,
	input wire logic                   serial_result_out_o,
	input wire logic                   serial_result_oe_o,
	input wire logic                   busy_o,
	input wire logic [RESULT_BITS-1:0] held_sample_o
);
	localparam int FLEN =
		(RESULT_BITS == RESULT_BITS_12) ? FRAME_LEN_12 : FRAME_LEN_10;
	logic [CNT_W-1:0] falls_reg;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			falls_reg <= CNT_ZERO;
		else if (frame_sel_n_i)
			falls_reg <= CNT_ZERO;
		else if ($fell(sclk_i))
			falls_reg <= falls_reg + CNT_ONE;
	end
	a_drive_after_sel: assert property (
		$fell(frame_sel_n_i) |-> ##[2:5] serial_result_oe_o) else $error("oe late");
	a_lead_zero: assert property (
		$rose(serial_result_oe_o) |-> !serial_result_out_o) else $error("lead bit");
	a_bit_on_fall: assert property (
		(sclk_i && !frame_sel_n_i)[*6] |-> $stable(serial_result_out_o))
		else $error("bit moved");
	a_count_release: assert property (
		$fell(serial_result_oe_o) && !frame_sel_n_i |-> falls_reg == FLEN)
		else $error("release count");
	a_zero_released: assert property (
		!serial_result_oe_o |-> !serial_result_out_o) else $error("idle bit");
	a_release_idle: assert property (
		frame_sel_n_i[*6] |-> !serial_result_oe_o) else $error("line held");
	a_conv_paced: assert property (
		(busy_o && sclk_i && !frame_sel_n_i)[*8] |=> busy_o) else $error("busy");
	a_start_by_sel: assert property (
		$rose(busy_o) |-> !$past(frame_sel_n_i, 2)) else $error("start");
	a_hold_sample: assert property (
		busy_o && $past(busy_o) |-> $stable(held_sample_o)) else $error("held");
endmodule

/* File: testbench/adc_host_model.sv */
// Host model: frames a transfer and collects the serial bits.
`timescale 1ns/1ns
module adc_host_model (
	input  wire logic        clk_sys_i,
	input  wire logic        data_i,
	output logic             sel_n_o,
	output logic             sclk_o,
	output logic [15:0]      word_o
);
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b1;
		word_o = 16'h0000;
	end
	task automatic run(input int n, input int gap);
		word_o = 16'h0000;
		sel_n_o = 1'b0;
		repeat (8 + gap) @(negedge clk_sys_i);
		for (int i = 0; i < n; i++) begin
			word_o = {word_o[14:0], data_i};
			sclk_o = 1'b0;
			repeat (8) @(negedge clk_sys_i);
			sclk_o = 1'b1;
			repeat (8) @(negedge clk_sys_i);
		end
		sel_n_o = 1'b1;
		repeat (20) @(negedge clk_sys_i);
	endtask
endmodule

/* File: testbench/serial_adc_frame_timing_tb_top.sv */
// Testbench top for the converter frame timing block.
`timescale 1ns/1ns
module serial_adc_frame_timing_tb_top;
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [11:0] val12 = 12'h000;
	logic [9:0]  val10 = 10'h000;
	logic        out12, oe12, busy12, out10, oe10, sel12, sck12, sel10, sck10;
	logic [15:0] w12, w10;
	logic [11:0] held12;
	int          err_count = 0;
	int          checks = 0;
	initial forever #10 clk_sys_i = ~clk_sys_i;
	serial_adc_frame_timing #(.RESULT_BITS(12)) serial_adc_frame_timing_inst (
		.clk_sys_i, .sys_rst_i, .frame_sel_n_i(sel12), .sclk_i(sck12),
		.sample_value_i(val12), .serial_result_out_o(out12),
		.serial_result_oe_o(oe12), .busy_o(busy12),
		.held_sample_o(held12));
	serial_adc_frame_timing #(.RESULT_BITS(10)) serial_adc_frame_timing_10_inst (
		.clk_sys_i, .sys_rst_i, .frame_sel_n_i(sel10), .sclk_i(sck10),
		.sample_value_i(val10), .serial_result_out_o(out10),
		.serial_result_oe_o(oe10), .busy_o(), .held_sample_o());
	adc_host_model adc_host_model_inst (.clk_sys_i,
		.data_i(oe12 ? out12 : ~out12), .sel_n_o(sel12), .sclk_o(sck12),
		.word_o(w12));
	adc_host_model adc_host_model_10_inst (.clk_sys_i,
		.data_i(oe10 ? out10 : ~out10), .sel_n_o(sel10), .sclk_o(sck10),
		.word_o(w10));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_read(input logic [11:0] v);
		val12 = v;
		val10 = v[11:2];
		fork
			adc_host_model_inst.run(16, 0);
			adc_host_model_10_inst.run(14, 0);
		join
		check(w12, {4'h0, v});
		check(w10, {6'h00, v[11:2]});
		check({busy12, oe12, oe10}, 3'b000);
	endtask
	task automatic t_stall();
		val12 = 12'h5A3;
		fork
			adc_host_model_inst.run(16, 40);
			begin
				repeat (30) @(negedge clk_sys_i);
				val12 = 12'hFFF;
				check({busy12, oe12}, 2'b11);
			end
		join
		check(w12, 16'h05A3);
		check(held12, 12'h5A3);
	endtask
	task automatic t_abort();
		adc_host_model_inst.run(6, 0);
		check({busy12, oe12}, 2'b00);
	endtask
	initial begin
		#1000000;
		err_count++;
		stop_test();
	end
	initial begin
		repeat (5) @(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		repeat (50) @(negedge clk_sys_i);
		t_read(12'hA5C);
		t_read(12'hFFF);
		t_abort();
		t_read(12'h001);
		t_stall();
		stop_test();
	end
endmodule
bind serial_adc_frame_timing adc_frame_sva #(.RESULT_BITS(RESULT_BITS))
	adc_frame_sva_inst (.clk_sys_i, .sys_rst_i, .frame_sel_n_i, .sclk_i,
	.sample_value_i, .serial_result_out_o, .serial_result_oe_o, .busy_o,
	.held_sample_o);
